// >>> gpol_pad_owner_lock_cfg.sv
// Pad ownership, configuration lock and community configuration logic
//
// Contract
// - Eight-bit field picks driver-mode interrupt line
// - Bits 19:16 select group for event dword2
// - Bits 15:12 select group for event dword1
// - Bits 11:8 select group for event dword0
// - Group events fill lowest bits of dword
// - Codes 9h and Dh-Fh are reserved
// - Bit 1 enables partition clock gating participation
// - Bit 0 enables local clock gating
// - Two-bit owner fields every four bits, reset 0
// - Owner code 00 gives pad to host
// - Host mode bit steers which status bits set
// - Host ownership imposes no access restriction
// - Codes 01, 10 firmware owned; 11 reserved
// - Lock bit blocks pad configuration writes
// - Lock bit also freezes interrupt enable bits
// - Unlock write raises management interrupt if enabled
// - Config word resets 36043200h, reserved read zero
// - Transmit lock freezes transmit level, unlock interrupts
// - Host software bit: 0 ACPI, 1 driver
`timescale 1ns/100ps
module gpol_pad_owner_lock_cfg #(
  parameter int NumPads = gpol_pkg::NumPads
) (
  input wire logic clk,
  input wire logic rst,
  input wire gpol_pkg::gpol_req_t regReq,
  output logic [31:0] regRdata,
  output logic regRvalid,
  input wire logic mgmtIntEnable,
  input wire logic [NumPads-1:0] hostSwOwn,
  input wire logic [NumPads-1:0] padEvent,
  input wire logic irqStatusAny,
  input wire logic [gpol_pkg::NumGroupCodes-1:0][23:0] groupEvent,
  output logic [gpol_pkg::NumDwords-1:0][31:0] gpeDword,
  output logic [7:0] driverIrqLine,
  output logic driverIrqReq,
  output logic partitionGatingEnable,
  output logic localGatingEnable,
  output logic [NumPads-1:0] padHostOwned,
  output logic [NumPads-1:0] padCfgWriteEn,
  output logic [NumPads-1:0] padEnWriteEn,
  output logic [NumPads-1:0] padTxWriteEn,
  output gpol_pkg::gpol_evt_t evtSet,
  output logic mgmtIntPulse
);

  // ==========================================================
  // Decode helpers
  function automatic logic isWrite(input gpol_pkg::gpol_req_t r, input logic [11:0] off);
    isWrite = r.wr && (r.addr == off);
  endfunction

  function automatic logic [31:0] gpeSelect(
    input logic [3:0] code,
    input logic [gpol_pkg::NumGroupCodes-1:0][23:0] ev
  );
    logic [23:0] bits;
    bits = 24'h000000;
    if (int'(code) < gpol_pkg::NumGroupCodes) begin
      bits = ev[code] & gpol_pkg::GroupMask[code];
    end
    gpeSelect = {8'h00, bits};
  endfunction

  // ==========================================================
  // Community configuration word
  logic [31:0] miscQ;

  always_ff @(posedge clk) begin
    if (rst) begin
      miscQ <= gpol_pkg::MiscReset;
    end else if (isWrite(regReq, gpol_pkg::OffMisc)) begin
      miscQ <= regReq.wdata & gpol_pkg::MiscWriteMask;
    end
  end

  assign driverIrqLine = miscQ[gpol_pkg::IrqSelLsb +: gpol_pkg::IrqSelW];
  assign driverIrqReq = irqStatusAny;
  assign partitionGatingEnable = miscQ[gpol_pkg::PartGateBit];
  assign localGatingEnable = miscQ[gpol_pkg::LocalGateBit];

  // ==========================================================
  // Event dword mapping
  logic [gpol_pkg::NumDwords-1:0][31:0] gpeQ;

  always_ff @(posedge clk) begin
    if (rst) begin
      gpeQ <= '0;
    end else begin
      gpeQ[0] <= gpeSelect(miscQ[gpol_pkg::Dw0SelLsb +: gpol_pkg::SelW], groupEvent);
      gpeQ[1] <= gpeSelect(miscQ[gpol_pkg::Dw1SelLsb +: gpol_pkg::SelW], groupEvent);
      gpeQ[2] <= gpeSelect(miscQ[gpol_pkg::Dw2SelLsb +: gpol_pkg::SelW], groupEvent);
    end
  end

  assign gpeDword = gpeQ;

  // ==========================================================
  // Ownership fields
  logic [1:0] ownQ [NumPads];

  for (genvar r = 0; r < gpol_pkg::NumOwnRegs; r++) begin : g_ownReg
    for (genvar f = 0; f < gpol_pkg::OwnPerReg; f++) begin : g_ownField
      always_ff @(posedge clk) begin
        if (rst) begin
          ownQ[r*gpol_pkg::OwnPerReg+f] <= gpol_pkg::GPOL_OWN_HOST;
        end else if (isWrite(regReq, gpol_pkg::OffOwn[r])) begin
          ownQ[r*gpol_pkg::OwnPerReg+f] <= regReq.wdata[f*gpol_pkg::OwnStride +: 2];
        end
      end
    end
  end

  // Firmware, hub and reserved codes all leave host status untouched
  for (genvar p = 0; p < NumPads; p++) begin : g_host
    assign padHostOwned[p] = (ownQ[p] == gpol_pkg::GPOL_OWN_HOST);
  end

  // ==========================================================
  // Configuration and transmit locks
  logic [gpol_pkg::NumGroups-1:0][23:0] lockQ;
  logic [gpol_pkg::NumGroups-1:0][23:0] txLockQ;
  logic [gpol_pkg::NumGroups-1:0] unlockHit;
  logic [gpol_pkg::NumGroups-1:0] txUnlockHit;

  for (genvar g = 0; g < gpol_pkg::NumGroups; g++) begin : g_lock
    always_ff @(posedge clk) begin
      if (rst) begin
        lockQ[g] <= gpol_pkg::LockReset;
      end else if (isWrite(regReq, gpol_pkg::OffLock[g])) begin
        lockQ[g] <= regReq.wdata[23:0];
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        txLockQ[g] <= gpol_pkg::LockReset;
      end else if (isWrite(regReq, gpol_pkg::OffTxLock[g])) begin
        txLockQ[g] <= regReq.wdata[23:0];
      end
    end

    assign unlockHit[g] = isWrite(regReq, gpol_pkg::OffLock[g]) &&
                          (|(lockQ[g] & ~regReq.wdata[23:0]));
    assign txUnlockHit[g] = isWrite(regReq, gpol_pkg::OffTxLock[g]) &&
                            (|(txLockQ[g] & ~regReq.wdata[23:0]));
  end

  // Ownership plays no part in these write enables
  assign padCfgWriteEn = ~lockQ;
  assign padEnWriteEn = ~lockQ;
  assign padTxWriteEn = ~txLockQ;

  // ==========================================================
  // Management interrupt on unlock
  logic mgmtIntQ;

  always_ff @(posedge clk) begin
    if (rst) begin
      mgmtIntQ <= 1'b0;
    end else begin
      mgmtIntQ <= mgmtIntEnable && (|unlockHit || |txUnlockHit);
    end
  end

  assign mgmtIntPulse = mgmtIntQ;

  // ==========================================================
  // Host input event steering
  gpol_pkg::gpol_evt_t evtQ;
  logic [NumPads-1:0] hostEvt;

  assign hostEvt = padEvent & padHostOwned;

  always_ff @(posedge clk) begin
    if (rst) begin
      evtQ <= '0;
    end else begin
      evtQ.inputSts <= hostEvt & hostSwOwn;
      evtQ.eventSts <= hostEvt & ~hostSwOwn;
      evtQ.nmiSts <= hostEvt & ~hostSwOwn;
      evtQ.mgmtSts <= hostEvt & ~hostSwOwn;
    end
  end

  assign evtSet = evtQ;

  // ==========================================================
  // Register read port
  logic [31:0] rdataD;
  logic [31:0] rdataQ;
  logic rvalidQ;

  always_comb begin
    rdataD = 32'h00000000;
    if (regReq.addr == gpol_pkg::OffMisc) begin
      rdataD = miscQ;
    end
    for (int r = 0; r < gpol_pkg::NumOwnRegs; r++) begin
      if (regReq.addr == gpol_pkg::OffOwn[r]) begin
        for (int f = 0; f < gpol_pkg::OwnPerReg; f++) begin
          rdataD[f*gpol_pkg::OwnStride +: 2] = ownQ[r*gpol_pkg::OwnPerReg+f];
        end
      end
    end
    for (int g = 0; g < gpol_pkg::NumGroups; g++) begin
      if (regReq.addr == gpol_pkg::OffLock[g]) begin
        rdataD = {8'h00, lockQ[g]};
      end
      if (regReq.addr == gpol_pkg::OffTxLock[g]) begin
        rdataD = {8'h00, txLockQ[g]};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdataQ <= 32'h00000000;
      rvalidQ <= 1'b0;
    end else begin
      rvalidQ <= regReq.rd;
      if (regReq.rd) begin
        rdataQ <= rdataD;
      end
    end
  end

  assign regRdata = rdataQ;
  assign regRvalid = rvalidQ;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_misc_after_reset: assert property ($fell(rst) |-> miscQ == 32'h36043200)
    else $error("config word not at reset value");
  a_misc_rsvd_zero: assert property ((miscQ & 32'h00f000fc) == 32'h00000000)
    else $error("reserved config bits not zero");
  a_irq_line_sel: assert property (driverIrqLine == miscQ[31:24])
    else $error("interrupt line select mismatch");
  a_unlock_pulse: assert property ((|unlockHit && mgmtIntEnable) |=> mgmtIntPulse)
    else $error("unlock did not raise management interrupt");
  a_tx_unlock_pulse: assert property ((|txUnlockHit && mgmtIntEnable) |=> mgmtIntPulse)
    else $error("tx unlock did not raise management interrupt");
  a_pulse_needs_cause: assert property (mgmtIntPulse |->
    $past(mgmtIntEnable) && $past(|unlockHit || |txUnlockHit))
    else $error("management interrupt without enabled unlock");
  a_lock_blocks_cfg: assert property ((isWrite(regReq, 12'h080) && regReq.wdata[0])
    |=> !padCfgWriteEn[0] && !padEnWriteEn[0])
    else $error("lock did not block configuration writes");
  a_driver_mode_evt: assert property ((padEvent[0] && padHostOwned[0] && hostSwOwn[0])
    |=> evtSet.inputSts[0] && !evtSet.eventSts[0])
    else $error("driver mode event steered wrongly");
  a_acpi_mode_evt: assert property ((padEvent[0] && padHostOwned[0] && !hostSwOwn[0])
    |=> !evtSet.inputSts[0] && evtSet.mgmtSts[0] && evtSet.nmiSts[0])
    else $error("ACPI mode event steered wrongly");
  a_fw_no_evt: assert property ((ownQ[0] == gpol_pkg::GPOL_OWN_FW)
    |=> !evtSet.inputSts[0] && !evtSet.eventSts[0])
    else $error("firmware owned pad reached host status");
  a_gpe_dw0_map: assert property (gpeDword[0][31:24] == 8'h00)
    else $error("event dword upper bits used");
  a_read_latency: assert property (regReq.rd |=> regRvalid)
    else $error("read not answered next cycle");

  // ==========================================================
  // Configuration word and event dword checks
  a_local_gate: assert property (localGatingEnable == miscQ[gpol_pkg::LocalGateBit])
    else $error("local gating enable mismatch");
  a_part_gate: assert property (partitionGatingEnable == miscQ[gpol_pkg::PartGateBit])
    else $error("partition gating enable mismatch");
  a_irq_req_follow: assert property (driverIrqReq == irqStatusAny)
    else $error("driver interrupt request mismatch");
  a_misc_wr_mask: assert property (isWrite(regReq, gpol_pkg::OffMisc) |=>
    miscQ == ($past(regReq.wdata) & gpol_pkg::MiscWriteMask))
    else $error("config word write mask wrong");
  a_dw2_reset: assert property ($fell(rst) |->
    miscQ[gpol_pkg::Dw2SelLsb +: gpol_pkg::SelW] == 4'h4)
    else $error("event dword2 selector reset wrong");
  a_dw1_reset: assert property ($fell(rst) |->
    miscQ[gpol_pkg::Dw1SelLsb +: gpol_pkg::SelW] == 4'h3)
    else $error("event dword1 selector reset wrong");
  a_dw0_reset: assert property ($fell(rst) |->
    miscQ[gpol_pkg::Dw0SelLsb +: gpol_pkg::SelW] == 4'h2)
    else $error("event dword0 selector reset wrong");
  a_gpe_rsvd_nine: assert property (
    (miscQ[gpol_pkg::Dw0SelLsb +: gpol_pkg::SelW] == 4'h9) |=> gpeDword[0] == 32'h00000000)
    else $error("reserved selector code produced events");
  a_gpe_rsvd_high: assert property (
    (miscQ[gpol_pkg::Dw1SelLsb +: gpol_pkg::SelW] > 4'hc) |=> gpeDword[1] == 32'h00000000)
    else $error("reserved selector code produced events");
  a_gpe_dw1_upper: assert property (gpeDword[1][31:24] == 8'h00)
    else $error("event dword1 upper bits used");
  a_gpe_dw2_upper: assert property (gpeDword[2][31:24] == 8'h00)
    else $error("event dword2 upper bits used");

  // ==========================================================
  // Ownership and event steering checks
  a_own_rsvd_zero: assert property (
    (regReq.rd && regReq.addr == gpol_pkg::OffOwn[3]) |=> (regRdata & 32'hcccccccc) == 32'h0)
    else $error("owner reserved bits not zero");
  a_hub_not_host: assert property (
    (ownQ[24] == gpol_pkg::GPOL_OWN_HUB) |-> !padHostOwned[24])
    else $error("hub owned pad counted as host");
  a_owner_no_gate: assert property (
    (ownQ[24] != gpol_pkg::GPOL_OWN_HOST && !lockQ[1][0]) |-> padCfgWriteEn[24])
    else $error("ownership restricted configuration writes");
  a_own_reset: assert property ($fell(rst) |-> &padHostOwned)
    else $error("owner fields not reset to host");
  a_evt_not_host: assert property (!padHostOwned[24] |=>
    !evtSet.nmiSts[24] && !evtSet.mgmtSts[24])
    else $error("non host pad reached host status");
  a_driver_masks: assert property (
    (padEvent[24] && padHostOwned[24] && hostSwOwn[24]) |=>
    !evtSet.nmiSts[24] && !evtSet.mgmtSts[24] && !evtSet.eventSts[24])
    else $error("driver mode event set event status");
  a_acpi_masks: assert property (
    (padEvent[24] && padHostOwned[24] && !hostSwOwn[24]) |=>
    evtSet.eventSts[24] && !evtSet.inputSts[24])
    else $error("ACPI mode event set input status");

  // ==========================================================
  // Lock checks
  a_tx_lock_blocks: assert property (
    (isWrite(regReq, gpol_pkg::OffTxLock[2]) && regReq.wdata[0]) |=> !padTxWriteEn[48])
    else $error("transmit lock did not block writes");
  a_lock_spares_tx: assert property (!txLockQ[1][0] |-> padTxWriteEn[24])
    else $error("config lock blocked transmit level");
  a_unlock_needs_en: assert property (!mgmtIntEnable |=> !mgmtIntPulse)
    else $error("management interrupt while disabled");
  a_lock_rsvd_zero: assert property (
    (regReq.rd && regReq.addr == gpol_pkg::OffLock[1]) |=> regRdata[31:24] == 8'h00)
    else $error("lock reserved bits not zero");
  a_lock_reset: assert property ($fell(rst) |-> &padCfgWriteEn)
    else $error("locks not cleared by reset");

  // ==========================================================
  // Read port checks
  a_rvalid_only_read: assert property (!regReq.rd |=> !regRvalid)
    else $error("read answer without read");
  a_rdata_hold: assert property (!regReq.rd |=> $stable(regRdata))
    else $error("read data changed without read");
  a_unmapped_read: assert property (
    (regReq.rd && regReq.addr == 12'h0fc) |=> regRdata == 32'h00000000)
    else $error("unmapped read not zero");

  c_unlock_irq: cover property (|unlockHit && mgmtIntEnable ##1 mgmtIntPulse);
  c_misc_write: cover property (isWrite(regReq, gpol_pkg::OffMisc));
  c_acpi_event: cover property (|evtSet.eventSts);
  c_driver_event: cover property (|evtSet.inputSts);
  c_tx_unlock_irq: cover property (|txUnlockHit && mgmtIntEnable ##1 mgmtIntPulse);

endmodule

// >>> gpol_pad_owner_lock_cfg_tb_top.sv
// Self-checking testbench for the pad owner and lock block
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin numErrors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module gpol_pad_owner_lock_cfg_tb_top;
  // ==========================================================
  // Signals
  localparam int Np = gpol_pkg::NumPads;
  logic clk = 1'b0;
  logic rst = 1'b1;
  gpol_pkg::gpol_req_t regReq = '0;
  logic [31:0] regRdata;
  logic regRvalid;
  logic mgmtIntEnable = 1'b0;
  logic [Np-1:0] hostSwOwn = '0;
  logic [Np-1:0] padEvent = '0;
  logic irqStatusAny = 1'b0;
  logic [gpol_pkg::NumGroupCodes-1:0][23:0] groupEvent;
  logic [gpol_pkg::NumDwords-1:0][31:0] gpeDword;
  logic [7:0] driverIrqLine;
  logic driverIrqReq;
  logic partitionGatingEnable;
  logic localGatingEnable;
  logic [Np-1:0] padHostOwned;
  logic [Np-1:0] padCfgWriteEn;
  logic [Np-1:0] padEnWriteEn;
  logic [Np-1:0] padTxWriteEn;
  gpol_pkg::gpol_evt_t evtSet;
  logic mgmtIntPulse;
  int numErrors = 0;
  int compares = 0;

  always #50 clk = ~clk;

  gpol_pad_owner_lock_cfg dut (
    .clk(clk), .rst(rst), .regReq(regReq), .regRdata(regRdata), .regRvalid(regRvalid),
    .mgmtIntEnable(mgmtIntEnable), .hostSwOwn(hostSwOwn), .padEvent(padEvent),
    .irqStatusAny(irqStatusAny), .groupEvent(groupEvent), .gpeDword(gpeDword),
    .driverIrqLine(driverIrqLine), .driverIrqReq(driverIrqReq),
    .partitionGatingEnable(partitionGatingEnable), .localGatingEnable(localGatingEnable),
    .padHostOwned(padHostOwned), .padCfgWriteEn(padCfgWriteEn),
    .padEnWriteEn(padEnWriteEn), .padTxWriteEn(padTxWriteEn), .evtSet(evtSet),
    .mgmtIntPulse(mgmtIntPulse)
  );

  // ==========================================================
  // Helpers
  function automatic logic [23:0] pat(input logic [3:0] c);
    return 24'ha5c35a ^ {6{c}};
  endfunction

  function automatic logic [31:0] gpe_exp(input logic [3:0] c);
    if (c == 4'h9 || c > 4'hc) begin
      return 32'h0;
    end
    return {8'h00, pat(c) & gpol_pkg::GroupMask[c]};
  endfunction

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk) regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk) regReq <= '0;
    #1;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk) regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk) regReq <= '0;
    #1;
    `CHK(regRvalid, 1'b1)
    `CHK(regRdata, e)
  endtask

  task automatic ev_chk(input int p, input logic [3:0] m);
    gpol_pkg::gpol_evt_t e;
    e = '0;
    e.inputSts[p] = m[3];
    e.eventSts[p] = m[2];
    e.nmiSts[p] = m[1];
    e.mgmtSts[p] = m[0];
    @(posedge clk) padEvent[p] <= 1'b1;
    @(posedge clk) padEvent <= '0;
    #1;
    `CHK(evtSet, e)
  endtask

  task automatic pulse_chk(input logic e);
    `CHK(mgmtIntPulse, e)
    @(posedge clk);
    #1;
    `CHK(mgmtIntPulse, 1'b0)
  endtask

  task automatic wrap_up();
    if (numErrors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial begin
    for (int c = 0; c < gpol_pkg::NumGroupCodes; c++) begin
      groupEvent[c] = pat(4'(c));
    end
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    #1;
    `CHK(padHostOwned, {Np{1'b1}})
    `CHK(padCfgWriteEn & padEnWriteEn & padTxWriteEn, {Np{1'b1}})
    `CHK(driverIrqLine, 8'h36)
    `CHK({partitionGatingEnable, localGatingEnable}, 2'b00)
    rd_chk(12'h010, 32'h36043200);
    rd_chk(12'h034, 32'h0);
    rd_chk(12'h088, 32'h0);
    rd_chk(12'h0fc, 32'h0);
    wr_reg(12'h010, 32'hffffffff);
    `CHK(driverIrqLine, 8'hff)
    `CHK({partitionGatingEnable, localGatingEnable}, 2'b11)
    rd_chk(12'h010, 32'hff0fff03);
    @(posedge clk) irqStatusAny <= 1'b1;
    #1;
    `CHK(driverIrqReq, 1'b1)
    @(posedge clk) irqStatusAny <= 1'b0;
    #1;
    `CHK(driverIrqReq, 1'b0)
    for (int k = 0; k < 16; k++) begin
      logic [3:0] s;
      s = 4'(k);
      wr_reg(12'h010, {8'h00, 4'h0, s, ~s, s + 4'h3, 8'h00});
      @(posedge clk);
      #1;
      `CHK(gpeDword[2], gpe_exp(s))
      `CHK(gpeDword[1], gpe_exp(~s))
      `CHK(gpeDword[0], gpe_exp(s + 4'h3))
      `CHK(gpeDword[0][31:24], 8'h00)
    end
    wr_reg(12'h010, 32'h00009900);
    @(posedge clk);
    #1;
    `CHK(gpeDword[0], 32'h0)
    wr_reg(12'h02c, 32'hffffffff);
    rd_chk(12'h02c, 32'h33333333);
    `CHK(padHostOwned[31:24], 8'h00)
    ev_chk(24, 4'b0000);
    wr_reg(12'h02c, 32'h00000012);
    `CHK(padHostOwned[31:24], 8'hfc)
    `CHK(padCfgWriteEn[31:24], 8'hff)
    ev_chk(24, 4'b0000);
    ev_chk(25, 4'b0000);
    wr_reg(12'h02c, 32'h0);
    `CHK(padHostOwned[31:24], 8'hff)
    ev_chk(24, 4'b0111);
    @(posedge clk) hostSwOwn[24] <= 1'b1;
    ev_chk(24, 4'b1000);
    wr_reg(12'h020, 32'h00000001);
    ev_chk(0, 4'b0000);
    wr_reg(12'h020, 32'h0);
    ev_chk(0, 4'b0111);
    @(posedge clk) hostSwOwn[0] <= 1'b1;
    ev_chk(0, 4'b1000);
    wr_reg(12'h080, 32'h00000001);
    `CHK(padCfgWriteEn[0], 1'b0)
    `CHK(padTxWriteEn[0], 1'b1)
    wr_reg(12'h080, 32'h0);
    pulse_chk(1'b0);
    wr_reg(12'h088, 32'hffffffff);
    pulse_chk(1'b0);
    `CHK(padCfgWriteEn[47:24], 24'h0)
    `CHK(padEnWriteEn[47:24], 24'h0)
    `CHK(padCfgWriteEn[23:0], 24'hffffff)
    rd_chk(12'h088, 32'h00ffffff);
    @(posedge clk) mgmtIntEnable <= 1'b1;
    wr_reg(12'h088, 32'h00fffffe);
    pulse_chk(1'b1);
    `CHK(padCfgWriteEn[24], 1'b1)
    wr_reg(12'h088, 32'h00fffffe);
    pulse_chk(1'b0);
    @(posedge clk) mgmtIntEnable <= 1'b0;
    wr_reg(12'h088, 32'h0);
    pulse_chk(1'b0);
    wr_reg(12'h09c, 32'h1);
    `CHK(padTxWriteEn[48], 1'b0)
    `CHK(padCfgWriteEn[48], 1'b1)
    @(posedge clk) mgmtIntEnable <= 1'b1;
    wr_reg(12'h09c, 32'h0);
    pulse_chk(1'b1);
    `CHK(padTxWriteEn[48], 1'b1)
    wrap_up();
  end

  // ==========================================================
  // Watchdog
  initial begin
    repeat (5000) @(posedge clk);
    numErrors++;
    wrap_up();
  end
endmodule

// >>> gpol_pkg.sv
// Shared constants and types for the pad owner and lock block
package gpol_pkg;

  // ==========================================================
  // Geometry
  localparam int PadsPerGroup = 24;
  localparam int NumGroups = 3;
  localparam int NumPads = 72;
  localparam int OwnPerReg = 8;
  localparam int NumOwnRegs = 9;
  localparam int OwnStride = 4;
  localparam int NumDwords = 3;
  localparam int NumGroupCodes = 13;

  // ==========================================================
  // Register offsets
  localparam logic [11:0] OffMisc = 12'h010;
  localparam logic [11:0] OffOwn [NumOwnRegs] = '{
    12'h020, 12'h024, 12'h028, 12'h02c, 12'h030, 12'h034, 12'h040, 12'h044, 12'h048};
  localparam logic [11:0] OffLock [NumGroups] = '{12'h080, 12'h088, 12'h098};
  localparam logic [11:0] OffTxLock [NumGroups] = '{12'h084, 12'h08c, 12'h09c};

  // ==========================================================
  // Miscellaneous configuration word layout
  localparam logic [31:0] MiscReset = 32'h36043200;
  localparam logic [31:0] MiscWriteMask = 32'hff0fff03;
  localparam int IrqSelLsb = 24;
  localparam int IrqSelW = 8;
  localparam int SelW = 4;
  localparam int Dw0SelLsb = 8;
  localparam int Dw1SelLsb = 12;
  localparam int Dw2SelLsb = 16;
  localparam int PartGateBit = 1;
  localparam int LocalGateBit = 0;
  localparam logic [23:0] LockReset = 24'h000000;

  // ==========================================================
  // Ownership codes
  typedef enum logic [1:0] {
    GPOL_OWN_HOST = 2'b00,
    GPOL_OWN_FW = 2'b01,
    GPOL_OWN_HUB = 2'b10,
    GPOL_OWN_RSVD = 2'b11
  } gpol_owner_t;

  // Valid pad bits of each group code, reserved codes empty
  localparam logic [23:0] GroupMask [16] = '{
    24'hffffff, 24'h00000c, 24'hffffff, 24'h0000ff,
    24'h000fff, 24'h0000ff, 24'hffffff, 24'h0fffff,
    24'h000030, 24'h000000, 24'hffffff, 24'hffffff,
    24'hffffff, 24'h000000, 24'h000000, 24'h000000};

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } gpol_req_t;

  typedef struct packed {
    logic [NumPads-1:0] inputSts;
    logic [NumPads-1:0] eventSts;
    logic [NumPads-1:0] nmiSts;
    logic [NumPads-1:0] mgmtSts;
  } gpol_evt_t;

endpackage
